// *** rtl/act_params.svh ***
// Purpose: offsets, field positions, reset values and counts of the conversion trigger block
// Assumes: 32-bit classic Wishbone, byte addresses
// Notes: definitions only
`ifndef ACT_PARAMS_SVH
`define ACT_PARAMS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define ACT_OFF_CTL0 8'h00
`define ACT_OFF_CTL1 8'h04
`define ACT_OFF_FLAG 8'h08
`define ACT_MEM_REGION 2'h1
// ----------------------------------------
// field positions
// ----------------------------------------
`define ACT_CTL0_SC 0
`define ACT_CTL0_ENC 1
`define ACT_CTL0_ON 4
`define ACT_CTL1_BUSY 0
`define ACT_CTL1_PULSE 3
`define ACT_FLG_DONE 0
`define ACT_FLG_OVF 1
`define ACT_FLG_TOV 2
`define ACT_FLG_HALT 3
// ----------------------------------------
// reset values and counts
// ----------------------------------------
`define ACT_SHT_RST 8'h04
`define ACT_CONV_CYCLES 13
`endif

// *** rtl/act_pkg.sv ***
// Purpose: types shared by the conversion trigger block
// Assumes: nothing
// Notes: one-hot state codes
package act_pkg;
  typedef enum logic [1:0] {
    ACT_SEQ_SINGLE = 2'h0,
    ACT_SEQ_CHAIN = 2'h1,
    ACT_SEQ_RPT_SINGLE = 2'h2,
    ACT_SEQ_RPT_CHAIN = 2'h3
  } act_seq_mode_t;
  typedef enum logic [2:0] {
    ACT_ST_IDLE = 3'h1,
    ACT_ST_CONV = 3'h2,
    ACT_ST_HALT = 3'h4
  } act_ctl_state_t;
  typedef enum logic [2:0] {
    ACT_E_IDLE = 3'h1,
    ACT_E_SAMPLE = 3'h2,
    ACT_E_CONV = 3'h4
  } act_eng_state_t;

  function automatic logic [31:0] act_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction
endpackage

// *** rtl/act_conv_if.sv ***
// Purpose: carrier between sequencer and conversion engine
// Assumes: single clock
// Notes: start is a one-cycle pulse
`timescale 1ns/1ps
interface act_conv_if #(parameter int RES_W = 12);
  logic start;
  logic [3:0] chan;
  logic [7:0] sht;
  logic busy;
  logic done;
  logic [RES_W-1:0] result;
  modport ctl (output start, chan, sht, input busy, done, result);
  modport eng (input start, chan, sht, output busy, done, result);
endinterface

// *** rtl/act_res_mem.sv ***
// Purpose: result memory, one word per channel slot
// Assumes: one write port, one read port
// Notes: read data registered, one cycle behind the address
`timescale 1ns/1ps
module act_res_mem
  import act_pkg::*;
#(
  parameter int W = 12,
  parameter int DEPTH = 16
)
(
  input wire logic clk_i, // clock
  input wire logic rst_i, // sync reset
  input wire logic we_i, // write strobe
  input wire logic [3:0] waddr_i, // write slot
  input wire logic [W-1:0] wdata_i, // write word
  input wire logic [3:0] raddr_i, // read slot
  output logic [W-1:0] rdata_o // registered read word
);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [W-1:0] rdata;
  } act_mem_st_t;
  act_mem_st_t q, d;

  always_comb
  begin
    d = q;
    if (we_i && 32'(waddr_i) < DEPTH)
    begin
      d.mem[waddr_i] = wdata_i;
    end
    // slots past the depth read as zero
    d.rdata = (32'(raddr_i) < DEPTH) ? q.mem[raddr_i] : '0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign rdata_o = q.rdata;
endmodule

// *** rtl/act_conv_eng.sv ***
// Purpose: sample and conversion timing of one conversion
// Assumes: analog result presented on adc_data_i at end of conversion
// Notes: start ignored while busy
`timescale 1ns/1ps
`include "act_params.svh"
module act_conv_eng
  import act_pkg::*;
#(
  parameter int RES_W = 12,
  parameter int CONV_CYCLES = `ACT_CONV_CYCLES
)
(
  input wire logic clk_i, // clock
  input wire logic rst_i, // sync reset
  act_conv_if.eng cv, // sequencer side
  input wire logic [RES_W-1:0] adc_data_i, // converter result
  output logic sample_hold_o // high while sampling
);
  localparam logic [7:0] CONV_M1 = 8'(CONV_CYCLES - 1);
  typedef struct packed {
    act_eng_state_t st;
    logic [7:0] cnt;
    logic done;
    logic [RES_W-1:0] result;
  } act_eng_st_t;
  act_eng_st_t q, d;

  always_comb
  begin
    d = q;
    d.done = 1'b0;
    unique case (q.st)
      ACT_E_IDLE:
      begin
        if (cv.start)
        begin
          d.st = ACT_E_SAMPLE;
          // zero sample time still samples one cycle
          d.cnt = (cv.sht == 8'h00) ? 8'h00 : cv.sht - 8'h01;
        end
      end
      ACT_E_SAMPLE:
      begin
        if (q.cnt == 8'h00)
        begin
          d.st = ACT_E_CONV;
          d.cnt = CONV_M1;
        end
        else
        begin
          d.cnt = q.cnt - 8'h01;
        end
      end
      ACT_E_CONV:
      begin
        if (q.cnt == 8'h00)
        begin
          d.st = ACT_E_IDLE;
          d.done = 1'b1;
          d.result = adc_data_i;
        end
        else
        begin
          d.cnt = q.cnt - 8'h01;
        end
      end
      default:
      begin
        d.st = ACT_E_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q <= '0;
      q.st <= ACT_E_IDLE;
    end
    else
    begin
      q <= d;
    end
  end

  assign cv.busy = (q.st != ACT_E_IDLE);
  assign cv.done = q.done;
  assign cv.result = q.result;
  assign sample_hold_o = (q.st == ACT_E_SAMPLE);

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_start_takes: assert property (q.st == ACT_E_IDLE && cv.start |=> sample_hold_o)
    else $error("engine did not start sampling");
  a_done_from_conv: assert property (cv.done |-> $past(q.st) == ACT_E_CONV && !cv.busy)
    else $error("done without conversion phase");
endmodule

// *** rtl/act_trig_ctl.sv ***
// Purpose: trigger arming and sequencing of a 12-bit converter, Wishbone register file
// Assumes: tmr_trig_i is a one-cycle pulse from the on-chip timer
// Notes: AFFECTED selects the faulty-revision behaviour
// Contract
// - affected: any control-0 write that leaves enable set rearms single timer mode
// - otherwise only enable bit rising arms sampling
// - affected: trigger while busy halts multi modes
// - affected: timer overflow flag never reports
//
// The placing of the registers and register access over Wishbone were decided locally.
`timescale 1ns/1ps
`include "act_params.svh"
module act_trig_ctl
  import act_pkg::*;
#(
  parameter bit AFFECTED = 1'b1,
  parameter int RES_W = 12,
  parameter int DEPTH = 16,
  parameter int CONV_CYCLES = `ACT_CONV_CYCLES
)
(
  input wire logic clk_i, // clock, 200 MHz
  input wire logic rst_i, // sync reset, active high
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // bus strobe
  input wire logic wb_we_i, // write enable
  input wire logic [7:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte lanes
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // acknowledge
  input wire logic tmr_trig_i, // timer sample trigger
  input wire logic [RES_W-1:0] adc_data_i, // converter result
  output logic [3:0] ch_sel_o, // channel slot
  output logic sample_hold_o, // sampling window
  output logic busy_o // conversion busy
);
  generate
    if (DEPTH < 2 || DEPTH > 16 || RES_W < 1 || RES_W > 16 || CONV_CYCLES < 1 || CONV_CYCLES > 256)
    begin : g_bad
      $error("act_trig_ctl: unsupported parameter value");
    end
  endgenerate

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    act_ctl_state_t st;
    logic on;
    logic enc;
    logic [7:0] sht;
    act_seq_mode_t seq;
    logic pulse;
    logic [3:0] end_idx;
    logic [3:0] idx;
    logic armed;
    logic [3:0] flg;
    logic phase;
    logic ack;
    logic [31:0] dat;
  } act_ctl_st_t;
  act_ctl_st_t q, d;

  act_conv_if #(.RES_W(RES_W)) cv ();
  logic [RES_W-1:0] mem_rdata;
  logic mem_we;
  logic bus_req;
  logic bus_go;
  logic wr_ctl0;
  logic wr_ctl1;
  logic wr_flag;
  logic sc;
  logic trig;
  logic last;
  logic [31:0] w0;
  logic [31:0] w1;
  logic [31:0] ctl0_img;
  logic [31:0] ctl1_img;

  act_conv_eng #(.RES_W(RES_W), .CONV_CYCLES(CONV_CYCLES)) u_eng (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cv(cv.eng),
    .adc_data_i(adc_data_i),
    .sample_hold_o(sample_hold_o)
  );

  act_res_mem #(.W(RES_W), .DEPTH(DEPTH)) u_mem (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .we_i(mem_we),
    .waddr_i(q.idx),
    .wdata_i(cv.result),
    .raddr_i(wb_adr_i[5:2]),
    .rdata_o(mem_rdata)
  );

  assign ctl0_img = {16'h0000, q.sht, 3'h0, q.on, 2'h0, q.enc, 1'b0};
  assign ctl1_img = {20'h00000, q.end_idx, 4'h0, q.pulse, q.seq, busy_o};
  assign bus_req = wb_cyc_i && wb_stb_i && !q.ack;
  assign bus_go = bus_req && q.phase;
  assign wr_ctl0 = bus_go && wb_we_i && wb_adr_i == `ACT_OFF_CTL0;
  assign wr_ctl1 = bus_go && wb_we_i && wb_adr_i == `ACT_OFF_CTL1;
  assign wr_flag = bus_go && wb_we_i && wb_adr_i == `ACT_OFF_FLAG;
  assign w0 = act_merge(ctl0_img, wb_dat_i, wb_sel_i);
  assign w1 = act_merge(ctl1_img, wb_dat_i, wb_sel_i);
  // start bit is a strobe, it never stores
  assign sc = wr_ctl0 && wb_sel_i[0] && wb_dat_i[`ACT_CTL0_SC];
  assign trig = q.pulse ? tmr_trig_i : sc;
  assign last = (q.idx == q.end_idx);
  assign mem_we = cv.done && q.st == ACT_ST_CONV;
  assign cv.chan = q.idx;
  assign cv.sht = q.sht;

  always_comb
  begin
    d = q;
    d.ack = 1'b0;
    cv.start = 1'b0;
    // ----------------------------------------
    // bus slave: ack two edges after the request
    // ----------------------------------------
    if (bus_req)
    begin
      d.phase = !q.phase;
    end
    if (bus_go)
    begin
      d.ack = 1'b1;
      if (wb_adr_i[7:6] == `ACT_MEM_REGION)
      begin
        d.dat = 32'(mem_rdata);
      end
      else if (wb_adr_i == `ACT_OFF_CTL0)
      begin
        d.dat = ctl0_img;
      end
      else if (wb_adr_i == `ACT_OFF_CTL1)
      begin
        d.dat = ctl1_img;
      end
      else if (wb_adr_i == `ACT_OFF_FLAG)
      begin
        d.dat = {28'h0000000, q.flg};
      end
      else
      begin
        d.dat = 32'h00000000;
      end
    end
    if (wr_ctl0)
    begin
      d.enc = w0[`ACT_CTL0_ENC];
      d.on = w0[`ACT_CTL0_ON];
      d.sht = w0[15:8];
      if (!q.enc && d.enc)
      begin
        d.armed = 1'b1;
        d.idx = 4'h0;
      end
      else if (AFFECTED && d.enc && q.pulse && q.seq == ACT_SEQ_SINGLE)
      begin
        d.armed = 1'b1;
      end
      if (!d.enc)
      begin
        d.armed = 1'b0;
      end
    end
    // mode fields are locked while conversions are enabled
    if (wr_ctl1 && !q.enc)
    begin
      d.seq = act_seq_mode_t'(w1[2:1]);
      d.pulse = w1[`ACT_CTL1_PULSE];
      d.end_idx = w1[11:8];
    end
    // write one to clear; hardware sets below win
    if (wr_flag && wb_sel_i[0])
    begin
      d.flg = q.flg & ~wb_dat_i[3:0];
    end
    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    unique case (q.st)
      ACT_ST_IDLE:
      begin
        if (trig && q.on && q.enc && q.armed && !cv.busy)
        begin
          cv.start = 1'b1;
          d.st = ACT_ST_CONV;
        end
      end
      ACT_ST_CONV:
      begin
        if (!q.on)
        begin
          d.st = ACT_ST_IDLE;
        end
        else if (trig && AFFECTED && q.seq != ACT_SEQ_SINGLE)
        begin
          d.st = ACT_ST_HALT;
          d.flg[`ACT_FLG_HALT] = 1'b1;
        end
        else
        begin
          if (trig)
          begin
            d.flg[`ACT_FLG_OVF] = 1'b1;
            d.flg[`ACT_FLG_TOV] = !AFFECTED;
          end
          if (cv.done)
          begin
            d.st = ACT_ST_IDLE;
            d.flg[`ACT_FLG_DONE] = 1'b1;
            unique case (q.seq)
              ACT_SEQ_SINGLE: d.armed = 1'b0;
              ACT_SEQ_RPT_SINGLE: d.armed = 1'b1;
              ACT_SEQ_CHAIN:
              begin
                d.idx = last ? 4'h0 : q.idx + 4'h1;
                d.armed = !last;
              end
              ACT_SEQ_RPT_CHAIN: d.idx = last ? 4'h0 : q.idx + 4'h1;
            endcase
          end
        end
      end
      ACT_ST_HALT:
      begin
        // only a full switch-off releases the halt
        if (!q.on && !q.enc)
        begin
          d.st = ACT_ST_IDLE;
          d.armed = 1'b0;
        end
      end
      default:
      begin
        d.st = ACT_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q <= '0;
      q.st <= ACT_ST_IDLE;
      q.sht <= `ACT_SHT_RST;
    end
    else
    begin
      q <= d;
    end
  end

  assign wb_dat_o = q.dat;
  assign wb_ack_o = q.ack;
  assign ch_sel_o = q.idx;
  // readable at any time, no side effect, for polling
  assign busy_o = (q.st == ACT_ST_CONV);

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !q.ack && !q.phase;
  endsequence
  sequence s_busy_trig;
    q.st == ACT_ST_CONV && q.on && trig && q.seq != ACT_SEQ_SINGLE;
  endsequence
  a_ack_latency: assert property (s_req ##1 (wb_cyc_i && wb_stb_i) |=> wb_ack_o)
    else $error("ack not given two edges after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_quirk_arm: assert property (AFFECTED && wr_ctl0 && d.enc && q.pulse && q.seq == ACT_SEQ_SINGLE |=> q.armed)
    else $error("control write did not rearm");
  a_write_no_arm: assert property (!AFFECTED && wr_ctl0 && q.enc && !q.armed |=> !q.armed)
    else $error("plain control write armed sampling");
  a_busy_halt: assert property (((AFFECTED == 1'b1) and s_busy_trig) |=> q.st == ACT_ST_HALT ##1 !cv.start)
    else $error("busy trigger did not halt");
  a_tov_quiet: assert property (AFFECTED |-> !q.flg[`ACT_FLG_TOV])
    else $error("timer overflow flag set in affected mode");
  a_halt_holds: assert property (q.st == ACT_ST_HALT && (q.on || q.enc) |=> q.st == ACT_ST_HALT && !busy_o)
    else $error("halt left without switch-off");
  // a halt also drops busy, without a result; only a normal finish is held to the write
  a_busy_ends_write: assert property ($fell(busy_o) && q.on && q.st == ACT_ST_IDLE |-> $past(mem_we))
    else $error("busy dropped before result written");
  a_accept_busy: assert property (cv.start |=> busy_o [*2])
    else $error("accepted trigger did not raise busy");
endmodule

// *** tb/act_tmr_model.sv ***
// Purpose: on-chip timer model driving the sample trigger
// Assumes: trigger is a one-cycle high pulse
// Notes: period kept above sample plus conversion time
`timescale 1ns/1ps
module act_tmr_model #(
  parameter int PERIOD = 20
)
(
  input wire logic clk_i, // clock
  input wire logic rst_i, // sync reset
  input wire logic run_i, // periodic firing
  input wire logic shot_i, // one extra pulse on request
  output logic trig_o // trigger pulse
);
  logic [15:0] cnt_q;
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !run_i)
    begin
      cnt_q <= 16'h0000;
    end
    else
    begin
      cnt_q <= (cnt_q == 16'(PERIOD - 1)) ? 16'h0000 : cnt_q + 16'h0001;
    end
  end
  // an extra shot is the only way to land a trigger mid-conversion
  always_ff @(posedge clk_i)
  begin
    trig_o <= !rst_i && ((run_i && cnt_q == 16'(PERIOD - 1)) || shot_i);
  end
endmodule

// *** tb/tb_top.sv ***
// Purpose: self-checking bench of the trigger block
// Assumes: classic Wishbone master, timer model on the trigger
// Notes: second instance shows the corrected behaviour
`timescale 1ns/1ps
`include "act_params.svh"
module tb_top;
  localparam int CV = 4;
  localparam int SH = 4;
  localparam int PER = 20;
  localparam logic [7:0] A0 = `ACT_OFF_CTL0;
  localparam logic [7:0] A1 = `ACT_OFF_CTL1;
  localparam logic [7:0] AF = `ACT_OFF_FLAG;
  logic clk_i, rst_i, cyc, stb, we, run, shot, trig, ack, busy, fbusy, sh;
  logic [7:0] adr;
  logic [31:0] dat, rd, rdf, q, fdat;
  logic [3:0] ch;
  logic [11:0] adc;
  int num_errors, n_checks;
  act_trig_ctl #(.CONV_CYCLES(CV)) i_act_trig_ctl (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(q),
    .wb_ack_o(ack), .tmr_trig_i(trig), .adc_data_i(adc), .ch_sel_o(ch), .sample_hold_o(sh), .busy_o(busy));
  act_trig_ctl #(.AFFECTED(1'b0), .CONV_CYCLES(CV)) i_act_trig_ctl_fix (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
    .wb_dat_o(fdat), .wb_ack_o(), .tmr_trig_i(trig), .adc_data_i(adc), .ch_sel_o(), .sample_hold_o(),
    .busy_o(fbusy));
  act_tmr_model #(.PERIOD(PER)) i_act_tmr_model (.clk_i(clk_i), .rst_i(rst_i), .run_i(run),
    .shot_i(shot), .trig_o(trig));
  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  task automatic finish_test();
    $display("errors=%0d checks=%0d", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0)
    begin
      $display("TB: PASS");
    end
    else
    begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic tmo();
    chk(32'h0, 32'h1);
    finish_test();
  endtask
  // ----------------------------------------
  // bus and trigger helpers
  // ----------------------------------------
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    if (n >= 20) tmo();
    rd = q;
    rdf = fdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic fire();
    @(posedge clk_i);
    shot <= 1'b1;
    @(posedge clk_i);
    shot <= 1'b0;
  endtask
  // busy length of the affected part, any busy at all of the fixed part
  task automatic obs(input logic em, input logic ef);
    int n, nf, ns;
    n = 0;
    nf = 0;
    ns = 0;
    repeat (40)
    begin
      @(posedge clk_i);
      n += int'(busy === 1'b1);
      nf += int'(fbusy === 1'b1);
      ns += int'(sh === 1'b1);
    end
    chk(32'(n >= SH + CV && n <= SH + CV + 2), 32'(em));
    // a start on the bus is seen one cycle late, so one sample cycle may be missed
    chk(32'(em ? (ns >= SH - 1 && ns <= SH) : ns == 0), 32'h1);
    chk(32'(nf != 0), 32'(ef));
  endtask
  task automatic idle();
    int n;
    n = 0;
    while ((busy !== 1'b0 || fbusy !== 1'b0) && n < 100)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 100) tmo();
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    wb(0, A0, 0);
    chk(rd, 32'h00000400);
    wb(0, A1, 0);
    chk(rd, 32'h00000000);
    wb(0, AF, 0);
    chk(rd, 32'h00000000);
    wb(1, 8'hFC, 32'hFFFFFFFF);
    wb(0, 8'hFC, 0);
    chk(rd, 32'h00000000);
    chk({busy, ch}, 32'h0);
  endtask
  task automatic t_sw();
    int n;
    wb(1, A0, 32'h00000412);
    wb(1, A0, 32'h00000413);
    wb(0, A1, 0);
    chk(rd[0], 1);
    n = 0;
    while (rd[0] !== 1'b0 && n < 30)
    begin
      wb(0, A1, 0);
      n++;
    end
    wb(0, 8'h40, 0);
    chk(rd, 32'h00000A5C);
    wb(0, AF, 0);
    chk(rd[0], 1);
    wb(1, AF, 32'h0000000F);
    wb(1, A0, 32'h00000410);
    wb(1, A0, 32'h00000412);
    wb(1, A0, 32'h00000413);
    obs(1, 1);
  endtask
  task automatic t_tmr();
    wb(1, A0, 32'h00000410);
    wb(1, A1, 32'h00000008);
    wb(1, A0, 32'h00000412);
    fire();
    obs(1, 1);
    fire();
    obs(0, 0);
    wb(1, A0, 32'h00000412);
    fire();
    obs(1, 0);
    wb(1, A0, 32'h00000410);
    wb(1, A0, 32'h00000412);
    fire();
    obs(1, 1);
  endtask
  task automatic t_halt();
    int n;
    wb(1, A0, 32'h00000410);
    wb(1, AF, 32'h0000000F);
    wb(1, A1, 32'h0000000C);
    wb(1, A0, 32'h00000412);
    run <= 1'b1;
    repeat (3 * PER) @(posedge clk_i);
    run <= 1'b0;
    idle();
    wb(0, AF, 0);
    chk(rd[3:0], 32'h1);
    chk(rdf[3:1], 32'h0);
    fire();
    n = 0;
    while (busy !== 1'b1 && n < 10)
    begin
      @(posedge clk_i);
      n++;
    end
    fire();
    repeat (4) @(posedge clk_i);
    chk(busy, 0);
    wb(0, AF, 0);
    chk(rd[3], 1);
    chk(rd[2], 0);
    chk(rdf[3:1], 32'h3);
    idle();
    fire();
    obs(0, 1);
  endtask
  task automatic t_rec();
    wb(1, A0, 32'h00000400);
    wb(1, A0, 32'h00000410);
    wb(1, A0, 32'h00000412);
    fire();
    obs(1, 1);
  endtask
  task automatic t_chain();
    wb(1, A0, 32'h00000410);
    wb(1, A1, 32'h00000102);
    wb(1, A0, 32'h00000412);
    adc <= 12'h123;
    wb(1, A0, 32'h00000413);
    idle();
    chk(ch, 32'h1);
    adc <= 12'h456;
    wb(1, A0, 32'h00000413);
    idle();
    chk(ch, 32'h0);
    wb(1, A0, 32'h00000413);
    repeat (4) @(posedge clk_i);
    chk(busy, 0);
    wb(0, 8'h40, 0);
    chk(rd, 32'h00000123);
    wb(0, 8'h44, 0);
    chk(rd, 32'h00000456);
  endtask
  initial
  begin
    num_errors = 0;
    n_checks = 0;
    {cyc, stb, we, run, shot} = 5'h00;
    adr = 8'h00;
    dat = 32'h0;
    adc = 12'hA5C;
    rst_i = 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_sw();
    t_tmr();
    t_halt();
    t_rec();
    t_chain();
    finish_test();
  end
endmodule
